// *** flic_pkg.sv ***
package flic_pkg;
    // source count and bit positions in the enable and priority register sets
    localparam int NSRC = 9;
    localparam int POS_EXT0 = 0;
    localparam int POS_TMR0 = 1;
    localparam int POS_EXT1 = 2;
    localparam int POS_TMR1 = 3;
    localparam int POS_SER = 4;
    localparam int POS_CMP = 6;
    localparam int POS_WDG = 4;
    localparam int POS_PWM = 5;
    localparam int POS_BOD = 6;
    localparam int POS_GEN = 7;
    localparam int POS_CMPWAKE = 5;

    // source index in arbitration order, 0 ranks first
    localparam int S_EXT0 = 0;
    localparam int S_BOD = 1;
    localparam int S_WDG = 2;
    localparam int S_TMR0 = 3;
    localparam int S_EXT1 = 4;
    localparam int S_TMR1 = 5;
    localparam int S_SER = 6;
    localparam int S_CMP = 7;
    localparam int S_PWM = 8;

    // apb byte offsets
    localparam logic [11:0] OFS_PEN = 12'h000;
    localparam logic [11:0] OFS_XEN = 12'h004;
    localparam logic [11:0] OFS_PPL = 12'h008;
    localparam logic [11:0] OFS_PPH = 12'h00c;
    localparam logic [11:0] OFS_XPL = 12'h010;
    localparam logic [11:0] OFS_XPH = 12'h014;
    localparam logic [11:0] OFS_CMPC = 12'h018;
    localparam logic [11:0] OFS_FLAG = 12'h01c;
    localparam logic [11:0] OFS_STAT = 12'h020;
    localparam logic [11:0] OFS_ITCFG = 12'h024;

    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [NSRC-1:0] RST_FLAGS = 9'h000;
    localparam logic [3:0] RST_ISV = 4'h0;

    // timing: one machine cycle is four clocks, call takes four machine cycles
    localparam int CLK_PER_MC = 4;
    localparam int CALL_MC = 4;
    localparam logic [1:0] PH_C3 = 2'd2;
    localparam logic [1:0] PH_LAST = 2'd3;

    // vector addresses in arbitration order
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_BOD = 16'h002b;
    localparam logic [15:0] VEC_WDG = 16'h0053;
    localparam logic [15:0] VEC_TMR0 = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001b;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_CMP = 16'h0033;
    localparam logic [15:0] VEC_PWM = 16'h006b;

    typedef enum logic [1:0] {
        FLIC_IDLE = 2'b00,
        FLIC_CALL = 2'b01
    } flic_state_t;
endpackage

// *** flic_top.sv ***
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/10ps
// Operation
// - priority level is high bit and low bit; 11 highest, 00 lowest
// - running routine preempted only by strictly higher level request
// - level-3 routine in service blocks every other source
// - simultaneous different levels: higher level wins
// - equal level ties broken by fixed ranking ext0 first, pwm last
// - vectoring delivers the fixed service address of the winner
// - each source has enable and priority bits at matching positions
// - flag clearing: edge ext and timers by hardware on vector, level ext follows pin
// - ext0, ext1, brownout wake; watchdog only on rc clock; timers, serial, pwm never
// - comparator wakes only while comparator wake enable is set
// - external pins sampled and flags updated in phase c3
// - timer overflow flags set at c3, polled next machine cycle
// - vectoring call lasts four machine cycles
// - no vectoring after enable/priority write nor the next instruction
// - vectoring only in the last machine cycle of an instruction
// - vector only if no equal/higher active, last cycle, no write, no return
// - denied requests are not remembered; each poll is fresh
// - global enable gates all sources
// - only return-from-service ends the active in-service level
module flic_top
    import flic_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // request sources
    input  wire logic        ext_request_pin_0,
    input  wire logic        ext_request_pin_1,
    input  wire logic        brownout_set,
    input  wire logic        watchdog_set,
    input  wire logic        timer0_ovf,
    input  wire logic        timer1_ovf,
    input  wire logic        serial_tx_set,
    input  wire logic        serial_rx_set,
    input  wire logic        comparator_set,
    input  wire logic        pwm_set,
    input  wire logic        watchdog_on_rc,
    // core handshake
    input  wire logic        instr_last_cycle,
    input  wire logic        instr_writes_irq_regs,
    input  wire logic        instr_is_return,
    output logic             vectoring_call,
    output logic [15:0]      vector_addr,
    output logic [1:0]       active_level,
    output logic             service_active,
    output logic             wake_request
);
    logic [7:0] primary_enable_reg;
    logic [7:0] extended_enable_reg;
    logic [7:0] primary_priority_low_reg;
    logic [7:0] primary_priority_high_reg;
    logic [7:0] extended_priority_low_reg;
    logic [7:0] extended_priority_high_reg;
    logic [7:0] comparator_control_reg;
    logic [1:0] ext_mode_r;        // bit set = edge mode
    logic [1:0] phase_r;
    logic [NSRC-1:0] flag_r;
    logic serial_tx_done_flag;
    logic serial_rx_done_flag;
    logic [1:0] pin_prev_r;
    logic [3:0] isv_r;
    logic [1:0] defer_r;
    logic [1:0] call_cnt_r;
    flic_state_t state_r;
    logic [NSRC-1:0] enable_v;
    logic [NSRC-1:0] prio_hi_v;
    logic [NSRC-1:0] prio_lo_v;
    logic [NSRC-1:0] poll_r;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] rd_mux;
    logic win_valid;
    logic [3:0] win_idx;
    logic [1:0] win_lvl;
    logic take;
    logic mc_tick;
    logic c3_tick;

    // gather enable and priority bits in arbitration order
    function automatic logic [NSRC-1:0] pick(input logic [7:0] p, input logic [7:0] x);
        pick = {p[POS_PWM], p[POS_CMP], p[POS_SER], p[POS_TMR1], p[POS_EXT1],
                p[POS_TMR0], x[POS_WDG], x[POS_BOD], p[POS_EXT0]};
        pick[S_PWM] = x[POS_PWM];
        pick[S_CMP] = p[POS_CMP];
    endfunction

    // fixed service address per source
    function automatic logic [15:0] vec_of(input logic [3:0] i);
        unique case (i)
            4'd0: vec_of = VEC_EXT0;
            4'd1: vec_of = VEC_BOD;
            4'd2: vec_of = VEC_WDG;
            4'd3: vec_of = VEC_TMR0;
            4'd4: vec_of = VEC_EXT1;
            4'd5: vec_of = VEC_TMR1;
            4'd6: vec_of = VEC_SER;
            4'd7: vec_of = VEC_CMP;
            default: vec_of = VEC_PWM;
        endcase
    endfunction

    assign enable_v = pick(primary_enable_reg, extended_enable_reg);
    assign prio_hi_v = pick(primary_priority_high_reg, extended_priority_high_reg);
    assign prio_lo_v = pick(primary_priority_low_reg, extended_priority_low_reg);

    // machine cycle phase counter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 2'd0;
        end else begin
            phase_r <= phase_r + 2'd1;
        end
    end
    assign c3_tick = (phase_r == PH_C3);
    assign mc_tick = (phase_r == PH_LAST);

    // apb decode, zero wait states
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !pwrite;
    assign pready = 1'b1;
    assign hit = (paddr <= OFS_ITCFG) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !hit;

    // configuration registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            primary_enable_reg <= RST_REG8;
            extended_enable_reg <= RST_REG8;
            primary_priority_low_reg <= RST_REG8;
            primary_priority_high_reg <= RST_REG8;
            extended_priority_low_reg <= RST_REG8;
            extended_priority_high_reg <= RST_REG8;
            comparator_control_reg <= RST_REG8;
            ext_mode_r <= 2'b00;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_PEN: primary_enable_reg <= pwdata[7:0];
                OFS_XEN: extended_enable_reg <= pwdata[7:0];
                OFS_PPL: primary_priority_low_reg <= pwdata[7:0];
                OFS_PPH: primary_priority_high_reg <= pwdata[7:0];
                OFS_XPL: extended_priority_low_reg <= pwdata[7:0];
                OFS_XPH: extended_priority_high_reg <= pwdata[7:0];
                OFS_CMPC: comparator_control_reg <= pwdata[7:0];
                OFS_ITCFG: ext_mode_r <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // pin history for edge detection, sampled at c3
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_prev_r <= 2'b11;
        end else if (c3_tick) begin
            pin_prev_r <= {ext_request_pin_1, ext_request_pin_0};
        end
    end

    // request flags: hardware set beats software clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag_r <= RST_FLAGS;
            serial_tx_done_flag <= 1'b0;
            serial_rx_done_flag <= 1'b0;
        end else begin
            if (wr_en && paddr == OFS_FLAG) begin
                flag_r <= pwdata[NSRC-1:0];
                serial_tx_done_flag <= pwdata[9];
                serial_rx_done_flag <= pwdata[10];
            end
            // hardware clear on vectoring for edge ext and timers
            if (take) begin
                if (win_idx == 4'(S_EXT0) && ext_mode_r[0]) flag_r[S_EXT0] <= 1'b0;
                if (win_idx == 4'(S_EXT1) && ext_mode_r[1]) flag_r[S_EXT1] <= 1'b0;
                if (win_idx == 4'(S_TMR0)) flag_r[S_TMR0] <= 1'b0;
                if (win_idx == 4'(S_TMR1)) flag_r[S_TMR1] <= 1'b0;
            end
            if (c3_tick) begin
                // external flags: edge sets, level follows inverted pin
                if (ext_mode_r[0]) begin
                    if (pin_prev_r[0] && !ext_request_pin_0) flag_r[S_EXT0] <= 1'b1;
                end else begin
                    flag_r[S_EXT0] <= !ext_request_pin_0;
                end
                if (ext_mode_r[1]) begin
                    if (pin_prev_r[1] && !ext_request_pin_1) flag_r[S_EXT1] <= 1'b1;
                end else begin
                    flag_r[S_EXT1] <= !ext_request_pin_1;
                end
                if (timer0_ovf) flag_r[S_TMR0] <= 1'b1;
                if (timer1_ovf) flag_r[S_TMR1] <= 1'b1;
                if (serial_tx_set) serial_tx_done_flag <= 1'b1;
                if (serial_rx_set) serial_rx_done_flag <= 1'b1;
            end
            if (brownout_set) flag_r[S_BOD] <= 1'b1;
            if (watchdog_set) flag_r[S_WDG] <= 1'b1;
            if (comparator_set) flag_r[S_CMP] <= 1'b1;
            if (pwm_set) flag_r[S_PWM] <= 1'b1;
            flag_r[S_SER] <= 1'b0;
        end
    end

    // poll snapshot taken at the end of each machine cycle, evaluated next cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            poll_r <= RST_FLAGS;
        end else if (mc_tick) begin
            poll_r <= (flag_r | ({8'h00, 1'b0} | (9'((serial_tx_done_flag | serial_rx_done_flag)) << S_SER)))
                      & enable_v & {NSRC{primary_enable_reg[POS_GEN]}};
        end
    end

    // arbitration: highest level, then ranking order
    always_comb begin
        win_valid = 1'b0;
        win_idx = 4'd0;
        win_lvl = 2'd0;
        for (int l = 3; l >= 0; l--) begin
            for (int i = NSRC - 1; i >= 0; i--) begin
                if (!win_valid || (win_lvl == 2'(l))) begin
                    if (poll_r[i] && {prio_hi_v[i], prio_lo_v[i]} == 2'(l)) begin
                        if (!win_valid || win_lvl == 2'(l)) begin
                            win_idx = 4'(i);
                        end
                    end
                end
            end
            if (!win_valid) begin
                for (int i = 0; i < NSRC; i++) begin
                    if (poll_r[i] && {prio_hi_v[i], prio_lo_v[i]} == 2'(l)) win_valid = 1'b1;
                end
                if (win_valid) win_lvl = 2'(l);
            end
        end
    end

    // accept only above highest in-service level and at an allowed instruction end
    always_comb begin
        take = 1'b0;
        if (win_valid && state_r == FLIC_IDLE && mc_tick && instr_last_cycle
            && primary_enable_reg[POS_GEN]
            && !instr_writes_irq_regs && !instr_is_return && defer_r == 2'd0) begin
            if (!isv_r[3]) begin
                take = (isv_r >> win_lvl) == 4'h0;
            end
        end
    end

    // deferral across a register write and the instruction after it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            defer_r <= 2'd0;
        end else if (mc_tick && instr_last_cycle) begin
            if (instr_writes_irq_regs) defer_r <= 2'd1;
            else if (defer_r != 2'd0) defer_r <= defer_r - 2'd1;
        end
    end

    // in-service markers per level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            isv_r <= RST_ISV;
        end else if (take) begin
            isv_r[win_lvl] <= 1'b1;
        end else if (mc_tick && instr_last_cycle && instr_is_return) begin
            if (isv_r[3]) isv_r[3] <= 1'b0;
            else if (isv_r[2]) isv_r[2] <= 1'b0;
            else if (isv_r[1]) isv_r[1] <= 1'b0;
            else isv_r[0] <= 1'b0;
        end
    end

    // vectoring call sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= FLIC_IDLE;
            call_cnt_r <= 2'd0;
            vector_addr <= 16'h0000;
        end else begin
            unique case (state_r)
                FLIC_IDLE: if (take) begin
                    state_r <= FLIC_CALL;
                    call_cnt_r <= 2'(CALL_MC - 1);
                    vector_addr <= vec_of(win_idx);
                end
                FLIC_CALL: if (mc_tick) begin
                    if (call_cnt_r == 2'd0) state_r <= FLIC_IDLE;
                    else call_cnt_r <= call_cnt_r - 2'd1;
                end
            endcase
        end
    end
    assign vectoring_call = (state_r == FLIC_CALL);
    assign service_active = |isv_r;
    assign active_level = isv_r[3] ? 2'd3 : isv_r[2] ? 2'd2 : isv_r[1] ? 2'd1 : 2'd0;

    // power-down wake sources
    assign wake_request = flag_r[S_EXT0] | flag_r[S_EXT1] | flag_r[S_BOD]
                          | (flag_r[S_WDG] & watchdog_on_rc)
                          | (flag_r[S_CMP] & comparator_control_reg[POS_CMPWAKE]);

    // read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_PEN: rd_mux[7:0] = primary_enable_reg;
            OFS_XEN: rd_mux[7:0] = extended_enable_reg;
            OFS_PPL: rd_mux[7:0] = primary_priority_low_reg;
            OFS_PPH: rd_mux[7:0] = primary_priority_high_reg;
            OFS_XPL: rd_mux[7:0] = extended_priority_low_reg;
            OFS_XPH: rd_mux[7:0] = extended_priority_high_reg;
            OFS_CMPC: rd_mux[7:0] = comparator_control_reg;
            OFS_FLAG: rd_mux[10:0] = {serial_rx_done_flag, serial_tx_done_flag, flag_r};
            OFS_STAT: rd_mux[6:0] = {vectoring_call, active_level, isv_r};
            OFS_ITCFG: rd_mux[1:0] = ext_mode_r;
            default: ;
        endcase
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) prdata <= 32'h0000_0000;
        else if (rd_en && !penable) prdata <= rd_mux;
    end

    // checks
    a_global_gate: assert property (@(posedge mclk) disable iff (!resetn)
        !primary_enable_reg[POS_GEN] && $past(!primary_enable_reg[POS_GEN]) |-> !take)
        else $error("vector taken with global enable off");
    a_call_len: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(vectoring_call) |-> vectoring_call [*8] ##1 vectoring_call [*8] ##1 !vectoring_call)
        else $error("vectoring call too short");
    a_lvl3_block: assert property (@(posedge mclk) disable iff (!resetn)
        isv_r[3] |-> !take)
        else $error("vector during level 3 service");
    a_preempt_up: assert property (@(posedge mclk) disable iff (!resetn)
        take |-> (isv_r >> win_lvl) == 4'h0)
        else $error("preempt by non-higher level");
    a_last_cycle: assert property (@(posedge mclk) disable iff (!resetn)
        take |-> instr_last_cycle && !instr_is_return && !instr_writes_irq_regs)
        else $error("vector at illegal instruction point");
    a_isv_set: assert property (@(posedge mclk) disable iff (!resetn)
        take |=> isv_r[$past(win_lvl)])
        else $error("in-service marker not set");
    a_cmp_wake: assert property (@(posedge mclk) disable iff (!resetn)
        wake_request && !flag_r[S_EXT0] && !flag_r[S_EXT1] && !flag_r[S_BOD] && !flag_r[S_WDG]
        |-> comparator_control_reg[POS_CMPWAKE])
        else $error("comparator wake without enable");
    a_tmr_clear: assert property (@(posedge mclk) disable iff (!resetn)
        take && win_idx == 4'(S_TMR0) && !(c3_tick && timer0_ovf) |=> !flag_r[S_TMR0])
        else $error("timer0 flag not cleared on vectoring");
endmodule

// *** flic_core_model.sv ***
`timescale 1ns/10ps
module flic_core_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // pacing: 0 every machine cycle, 1 every other one, 2 never ends
    input  wire logic [1:0] pace,
    // core handshake
    output logic            instr_last_cycle,
    output logic            instr_writes_irq_regs,
    output logic            instr_is_return
);
    logic [1:0] ph_r;
    logic       odd_r;
    logic       ret_req = 1'b0;
    logic       wr_req = 1'b0;

    // levels change only at machine cycle boundaries, phase aligned after reset
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ph_r <= 2'd0;
            odd_r <= 1'b0;
            instr_last_cycle <= 1'b0;
            instr_writes_irq_regs <= 1'b0;
            instr_is_return <= 1'b0;
        end else begin
            ph_r <= ph_r + 2'd1;
            if (ph_r == 2'd3) begin
                odd_r <= ~odd_r;
                instr_is_return <= ret_req;
                instr_writes_irq_regs <= wr_req;
                instr_last_cycle <= ret_req | wr_req | (pace == 2'd0) | (pace == 2'd1 && odd_r);
            end
        end
    end

    // one single machine cycle instruction: return or register write
    task automatic instr(input logic ret, input logic wr);
        @(negedge mclk);
        ret_req = ret;
        wr_req = wr;
        @(posedge mclk iff ph_r == 2'd3);
        @(negedge mclk);
        ret_req = 1'b0;
        wr_req = 1'b0;
        @(posedge mclk iff ph_r == 2'd3);
    endtask
endmodule

// *** flic_tb.sv ***
`timescale 1ns/10ps
module testbench;
    import flic_pkg::*;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, slverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, mask;
    logic        ext_request_pin_0, ext_request_pin_1, brownout_set, watchdog_set, timer0_ovf, timer1_ovf;
    logic        serial_tx_set, serial_rx_set, comparator_set, pwm_set, watchdog_on_rc;
    logic        instr_last_cycle, instr_writes_irq_regs, instr_is_return, vectoring_call;
    logic        service_active, wake_request;
    logic [15:0] vector_addr;
    logic [1:0]  active_level, pace;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          fbit [9] = '{0, 1, 2, 3, 4, 5, 9, 7, 8};
    logic [15:0] vec [9] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h0033,
                             16'h006b};
    logic [8:0]  wk = 9'h013;

    flic_top dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_request_pin_0, .ext_request_pin_1, .brownout_set, .watchdog_set, .timer0_ovf, .timer1_ovf,
        .serial_tx_set, .serial_rx_set, .comparator_set, .pwm_set, .watchdog_on_rc, .instr_last_cycle,
        .instr_writes_irq_regs, .instr_is_return, .vectoring_call, .vector_addr, .active_level,
        .service_active, .wake_request);
    flic_core_model core (.mclk, .resetn, .pace, .instr_last_cycle, .instr_writes_irq_regs, .instr_is_return);

    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // wait for a vectoring call and check what it delivered
    task automatic service(input logic [15:0] va, input logic [1:0] lv);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (vectoring_call !== 1'b1 && n < 300);
        check(n < 300, 1'b1);
        n = 0;
        while (vectoring_call === 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check(n, 32'd16);
        check(vector_addr, va);
        check(active_level, lv);
        check(service_active, 1'b1);
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge mclk);
            seen = seen | vectoring_call;
        end
        check(seen, 1'b0);
    endtask

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, brownout_set, watchdog_set} = '0;
        {timer0_ovf, timer1_ovf, serial_tx_set, serial_rx_set, comparator_set, pwm_set, watchdog_on_rc} = '0;
        ext_request_pin_0 = 1'b1;
        ext_request_pin_1 = 1'b1;
        pace = 2'd1;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        // reset state, then an unmapped address
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 12'(4 * i), '0);
            check(rd, '0);
        end
        check({vectoring_call, vector_addr, active_level, service_active}, '0);
        apb(1'b0, 12'h028, '0);
        check(slverr, 1'b1);
        check(rd, '0);
        // equal level requests held by global enable, then served by ranking
        apb(1'b1, OFS_XEN, 32'h0000_0070);
        apb(1'b1, OFS_ITCFG, 32'h0000_0003);
        apb(1'b1, OFS_PEN, 32'h0000_005f);
        mask = 32'h0000_03bf;
        apb(1'b1, OFS_FLAG, mask);
        quiet(40);
        apb(1'b1, OFS_PEN, 32'h0000_00df);
        for (int i = 0; i < 9; i++) begin
            service(vec[i], 2'd0);
            apb(1'b0, OFS_FLAG, '0);
            if (i inside {0, 3, 4, 5}) mask[fbit[i]] = 1'b0;
            check(rd & ~32'h0000_0040, mask);
            mask[fbit[i]] = 1'b0;
            apb(1'b1, OFS_FLAG, mask);
            core.instr(1'b1, 1'b0);
        end
        // deferral after a register write, then nesting by level
        pace <= 2'd2;
        apb(1'b1, OFS_XPL, 32'h0000_0020);
        apb(1'b1, OFS_XPH, 32'h0000_0060);
        apb(1'b1, OFS_FLAG, 32'h0000_0001);
        core.instr(1'b0, 1'b1);
        quiet(24);
        pace <= 2'd0;
        service(16'h0003, 2'd0);
        @(posedge mclk);
        timer0_ovf <= 1'b1;
        repeat (4) @(posedge mclk);
        timer0_ovf <= 1'b0;
        quiet(40);
        @(posedge mclk);
        brownout_set <= 1'b1;
        @(posedge mclk);
        brownout_set <= 1'b0;
        service(16'h002b, 2'd2);
        @(posedge mclk);
        pwm_set <= 1'b1;
        @(posedge mclk);
        pwm_set <= 1'b0;
        service(16'h006b, 2'd3);
        apb(1'b1, OFS_FLAG, 32'h0000_000a);
        quiet(40);
        core.instr(1'b1, 1'b0);
        quiet(40);
        check(active_level, 2'd2);
        apb(1'b1, OFS_FLAG, 32'h0000_0008);
        core.instr(1'b1, 1'b0);
        quiet(40);
        check({active_level, service_active}, 3'b001);
        core.instr(1'b1, 1'b0);
        service(16'h000b, 2'd0);
        apb(1'b0, OFS_FLAG, '0);
        check(rd & ~32'h0000_0040, '0);
        core.instr(1'b1, 1'b0);
        repeat (8) @(negedge mclk);
        check({active_level, service_active}, '0);
        // wake sources while the core never ends an instruction
        pace <= 2'd2;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, OFS_FLAG, 32'h0000_0001 << fbit[i]);
            repeat (4) @(negedge mclk);
            check(wake_request, wk[i]);
        end
        @(posedge mclk);
        watchdog_on_rc <= 1'b1;
        watchdog_set <= 1'b1;
        @(posedge mclk);
        watchdog_set <= 1'b0;
        apb(1'b1, OFS_FLAG, 32'h0000_0004);
        repeat (4) @(negedge mclk);
        check(wake_request, 1'b1);
        apb(1'b1, OFS_CMPC, 32'h0000_0020);
        apb(1'b1, OFS_FLAG, 32'h0000_0080);
        repeat (4) @(negedge mclk);
        check(wake_request, 1'b1);
        // level mode flag follows the inverted pin
        apb(1'b1, OFS_FLAG, '0);
        apb(1'b1, OFS_ITCFG, '0);
        ext_request_pin_1 <= 1'b0;
        repeat (8) @(posedge mclk);
        apb(1'b0, OFS_FLAG, '0);
        check(rd, 32'h0000_0010);
        ext_request_pin_1 <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b0, OFS_FLAG, '0);
        check(rd, '0);
        summarize();
    end
endmodule
